/* File: hdl/pic_init_and_mask_port.sv */
// Odd-port programming logic: init words two to four and the line mask.
// Assumes a synchronous I/O port bus: io_wr and io_rd are one-cycle strobes
// qualified by io_addr, and write data is valid with the strobe.
// The request level bits of word two are checked for zero but not stored.

`default_nettype none

module pic_init_and_mask_port #(
   parameter int LINES = 8
) (
   input  wire logic             clock,
   input  wire logic             reset_n,
   input  wire logic [15:0]      io_addr,
   input  wire logic             io_wr,
   input  wire logic             io_rd,
   input  wire logic [7:0]       io_wdata,
   output logic      [7:0]       io_rdata,
   output logic                  io_rdata_valid,
   input  wire logic [LINES-1:0] irq_req,
   input  wire logic [LINES-1:0] irq_ack,
   output logic      [LINES-1:0] irq_pending,
   output logic      [LINES-1:0] irq_presented,
   output logic      [4:0]       vector_base,
   output logic                  cascade_en,
   output logic                  special_nested,
   output logic                  auto_eoi,
   output logic                  x86_mode,
   output logic                  init_busy,
   output logic                  init_word_error
);

   // ==========================================================================
   // Elaboration check: the mask word is one byte wide.
   if (LINES != 8) begin : g_bad_lines
      $error("LINES must be 8: the mask word holds one bit per line.");
   end

   // ==========================================================================
   // Field helpers; in_mask is also a constant function for the checks below.
   function automatic logic in_mask(input logic [7:0] mask, input int pos);
      in_mask = mask[pos];
   endfunction : in_mask

   // Any reserved bit set in a word marks it as breaking the programming model.
   function automatic logic reserved_set(input logic [7:0] word, input logic [7:0] mask);
      reserved_set = ((word & mask) != '0);
   endfunction : reserved_set

   // ==========================================================================
   // Elaboration checks on the field layout.
   // The vector field must be exactly as wide as the vector_base port.
   if ($bits(vector_base) !=
       pic_init_pkg::VEC_BASE_HI - pic_init_pkg::VEC_BASE_LO + 1) begin : g_bad_vec_field
      $error("The vector base field must be as wide as the vector_base port.");
   end

   // Every single-bit field must fall inside the data byte.
   if (pic_init_pkg::FIRST_WORD_MARK_BIT >= $bits(io_wdata) ||
       pic_init_pkg::CASCADE_EN_BIT >= $bits(io_wdata) ||
       pic_init_pkg::SPECIAL_NEST_BIT >= $bits(io_wdata) ||
       pic_init_pkg::AUTO_EOI_BIT >= $bits(io_wdata) ||
       pic_init_pkg::CPU_MODE_BIT >= $bits(io_wdata)) begin : g_bad_bit_pos
      $error("A mode field position lies outside the data byte.");
   end

   // A reserved mask over a field in use would flag legal settings of that field.
   if ((pic_init_pkg::W2_RESERVED_MASK >> pic_init_pkg::VEC_BASE_LO) != '0) begin : g_bad_w2
      $error("The word two reserved mask overlaps the vector field.");
   end
   if (in_mask(pic_init_pkg::W3_RESERVED_MASK, pic_init_pkg::CASCADE_EN_BIT)) begin : g_bad_w3
      $error("The word three reserved mask covers the cascade enable bit.");
   end
   if (in_mask(pic_init_pkg::W4_RESERVED_MASK, pic_init_pkg::SPECIAL_NEST_BIT) ||
       in_mask(pic_init_pkg::W4_RESERVED_MASK, pic_init_pkg::AUTO_EOI_BIT) ||
       in_mask(pic_init_pkg::W4_RESERVED_MASK, pic_init_pkg::CPU_MODE_BIT)) begin : g_bad_w4
      $error("The word four reserved mask covers a mode bit.");
   end

   // ==========================================================================
   // Address decode, used for both reads and writes.
   function automatic logic port_hit(input logic [15:0] addr, input logic [15:0] port);
      port_hit = (addr == port);
   endfunction : port_hit

   // ==========================================================================
   // All state of the port.
   typedef struct packed {
      pic_init_pkg::seq_state_t seq;
      logic [4:0]               vec;
      logic                     cascade;
      logic                     nested;
      logic                     aeoi;
      logic                     cpu;
      logic [7:0]               mask;
      logic [7:0]               rdata;
      logic                     rvalid;
      logic                     werr;
      logic                     busy;  // Words two to four still awaited.
   } port_state_t;

   port_state_t state_reg;
   port_state_t state_next;

   logic first_word_wr;
   logic odd_wr;
   logic odd_rd;

   // Strobe decode: a first init word is an even-port write with bit 4 set.
   always_comb begin
      first_word_wr = io_wr && port_hit(io_addr, pic_init_pkg::EVEN_PORT_ADDR)
                      && io_wdata[pic_init_pkg::FIRST_WORD_MARK_BIT];
      odd_wr = io_wr && port_hit(io_addr, pic_init_pkg::ODD_PORT_ADDR);
      odd_rd = io_rd && port_hit(io_addr, pic_init_pkg::ODD_PORT_ADDR);
   end

   // ==========================================================================
   // Next-state logic: init sequencer, mode fields, mask and read data.
   always_comb begin
      state_next = state_reg;
      state_next.rvalid = 1'b0;

      // A first init word restarts the sequence and clears the mask.
      if (first_word_wr) begin
         state_next.seq  = pic_init_pkg::SEQ_WAIT_W2;
         state_next.mask = pic_init_pkg::MASK_RESET;
         state_next.werr = 1'b0;
      end else if (odd_wr) begin
         case (state_reg.seq)
            pic_init_pkg::SEQ_WAIT_W2: begin
               // Vector base address bits; the low level field is not stored.
               state_next.vec = io_wdata[pic_init_pkg::VEC_BASE_HI:pic_init_pkg::VEC_BASE_LO];
               if (reserved_set(io_wdata, pic_init_pkg::W2_RESERVED_MASK)) begin
                  state_next.werr = 1'h1;
               end
               state_next.seq = pic_init_pkg::SEQ_WAIT_W3;
            end
            pic_init_pkg::SEQ_WAIT_W3: begin
               state_next.cascade = io_wdata[pic_init_pkg::CASCADE_EN_BIT];
               if (reserved_set(io_wdata, pic_init_pkg::W3_RESERVED_MASK)) begin
                  state_next.werr = 1'h1;
               end
               state_next.seq = pic_init_pkg::SEQ_WAIT_W4;
            end
            pic_init_pkg::SEQ_WAIT_W4: begin
               state_next.nested = io_wdata[pic_init_pkg::SPECIAL_NEST_BIT];
               state_next.aeoi   = io_wdata[pic_init_pkg::AUTO_EOI_BIT];
               state_next.cpu    = io_wdata[pic_init_pkg::CPU_MODE_BIT];
               // Reserved and buffered-mode bits must be zero; flag otherwise.
               if (reserved_set(io_wdata, pic_init_pkg::W4_RESERVED_MASK)) begin
                  state_next.werr = 1'h1;
               end
               state_next.seq = pic_init_pkg::SEQ_IDLE;
            end
            pic_init_pkg::SEQ_IDLE: begin
               state_next.mask = io_wdata;
            end
            default: begin
               state_next.seq = pic_init_pkg::SEQ_IDLE;
            end
         endcase
      end

      // Reads of the odd port return the mask; init words are write-only.
      if (odd_rd) begin
         state_next.rdata  = state_reg.mask;
         state_next.rvalid = 1'b1;
      end else begin
         state_next.rdata  = pic_init_pkg::RDATA_IDLE;
      end

      // Busy follows the next sequencer state so that init_busy comes from a
      // flip-flop and still rises in the cycle after the first init word.
      state_next.busy = (state_next.seq != pic_init_pkg::SEQ_IDLE);
   end

   // ==========================================================================
   // State register.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_reg.seq     <= pic_init_pkg::SEQ_IDLE;
         state_reg.vec     <= pic_init_pkg::VEC_RESET;
         state_reg.cascade <= 1'b0;
         state_reg.nested  <= 1'b0;
         state_reg.aeoi    <= 1'b0;
         state_reg.cpu     <= 1'b0;
         state_reg.mask    <= pic_init_pkg::MASK_RESET;
         state_reg.rdata   <= pic_init_pkg::RDATA_IDLE;
         state_reg.rvalid  <= 1'b0;
         state_reg.werr    <= 1'b0;
         state_reg.busy    <= 1'h0;
      end else begin
         state_reg <= state_next;
      end
   end

   // ==========================================================================
   // Request latch and mask gate; both outputs are flip-flops inside.
   line_mask_gate #(
      .LINES (LINES)
   ) u_gate (
      .clock         (clock),
      .reset_n       (reset_n),
      .req_in        (irq_req),
      .req_ack       (irq_ack),
      .mask          (state_reg.mask),
      .req_latched   (irq_pending),
      .req_presented (irq_presented)
   );

   // Outputs straight from the state register.
   assign io_rdata        = state_reg.rdata;
   assign io_rdata_valid  = state_reg.rvalid;
   assign vector_base     = state_reg.vec;
   assign cascade_en      = state_reg.cascade;
   assign special_nested  = state_reg.nested;
   assign auto_eoi        = state_reg.aeoi;
   assign x86_mode        = state_reg.cpu;
   assign init_busy       = state_reg.busy;
   assign init_word_error = state_reg.werr;

endmodule : pic_init_and_mask_port

`default_nettype wire

/* File: hdl/pic_init_pkg.sv */
// Constants for the odd-port programming logic of the interrupt controller.
// Assumes an 8-bit I/O port bus with one-cycle read and write strobes.
//
// What this block does
// - After the first init word, the next three odd-port writes are words two to four.
// - Word two bits 7..3 are stored as vector base address bits 7..3.
// - Word three bit 2 enables cascaded operation.
// - Word four bit 4 selects normal or special fully nested priority.
// - Word four bit 1 selects explicit or automatic end of interrupt.
// - Word four bit 0 selects older 8-bit or x86 processor mode.
// - Outside initialization the odd port reads and writes the line mask.
// - Mask bit n governs request line n; zero enables the line.

`default_nettype none

package pic_init_pkg;

   // ==========================================================================
   // Port addresses.
   localparam logic [15:0] EVEN_PORT_ADDR = 16'h0020;
   localparam logic [15:0] ODD_PORT_ADDR  = 16'h0021;

   // ==========================================================================
   // Field positions.
   localparam int FIRST_WORD_MARK_BIT = 4;  // Marks a first init word on the even port.
   localparam int VEC_BASE_HI         = 7;
   localparam int VEC_BASE_LO         = 3;
   localparam int VEC_LEVEL_HI        = 2;
   localparam int CASCADE_EN_BIT      = 2;
   localparam int SPECIAL_NEST_BIT    = 4;
   localparam int BUF_MODE_HI         = 3;
   localparam int BUF_MODE_LO         = 2;
   localparam int AUTO_EOI_BIT        = 1;
   localparam int CPU_MODE_BIT        = 0;

   // ==========================================================================
   // Reserved-bit masks used to flag words that break the programming model.
   localparam logic [7:0] W2_RESERVED_MASK = 8'h07;
   localparam logic [7:0] W3_RESERVED_MASK = 8'hF9;
   localparam logic [7:0] W4_RESERVED_MASK = 8'hEC;

   // ==========================================================================
   // Reset values.
   localparam logic [7:0] MASK_RESET    = 8'h00;
   localparam logic [4:0] VEC_RESET     = 5'h00;
   localparam logic [7:0] RDATA_IDLE    = 8'h00;

   // ==========================================================================
   // Initialization sequencer states.
   typedef enum logic [1:0] {
      SEQ_IDLE    = 2'b00,
      SEQ_WAIT_W2 = 2'b01,
      SEQ_WAIT_W3 = 2'b10,
      SEQ_WAIT_W4 = 2'b11
   } seq_state_t;

endpackage : pic_init_pkg

`default_nettype wire

/* File: hdl/line_mask_gate.sv */
// Request latch and mask gate for the interrupt lines.
// Assumes requests and acknowledges are synchronous to clock.

`default_nettype none

module line_mask_gate #(
   parameter int LINES = 8
) (
   input  wire logic             clock,
   input  wire logic             reset_n,
   input  wire logic [LINES-1:0] req_in,
   input  wire logic [LINES-1:0] req_ack,
   input  wire logic [LINES-1:0] mask,
   output logic      [LINES-1:0] req_latched,
   output logic      [LINES-1:0] req_presented
);

   // ==========================================================================
   // State of the gate.
   typedef struct packed {
      logic [LINES-1:0] latched;
      logic [LINES-1:0] presented;
   } gate_state_t;

   gate_state_t gate_reg;
   gate_state_t gate_next;

   // Requests stick until acknowledged; a new request beats a clear.
   always_comb begin
      gate_next = gate_reg;
      gate_next.latched = (gate_reg.latched & ~req_ack) | req_in;
      gate_next.presented = gate_next.latched & ~mask;
   end

   // State register.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         gate_reg <= '0;
      end else begin
         gate_reg <= gate_next;
      end
   end

   assign req_latched   = gate_reg.latched;
   assign req_presented = gate_reg.presented;

endmodule : line_mask_gate

`default_nettype wire

/* File: dv/init_port_checker.sv */
// Checker for the odd-port programming logic, bound to its top module.
// Assumes one clock, reset_n low clears all, strobes of one cycle.
`default_nettype none
module init_port_checker #(
   parameter int LINES = 8
) (
   input wire logic             clock,
   input wire logic             reset_n,
   input wire logic [15:0]      io_addr,
   input wire logic             io_wr,
   input wire logic             io_rd,
   input wire logic [7:0]       io_wdata,
   input wire logic [7:0]       io_rdata,
   input wire logic             io_rdata_valid,
   input wire logic [LINES-1:0] irq_req,
   input wire logic [LINES-1:0] irq_pending,
   input wire logic [LINES-1:0] irq_presented,
   input wire logic [4:0]       vector_base,
   input wire logic             cascade_en,
   input wire logic             special_nested,
   input wire logic             auto_eoi,
   input wire logic             x86_mode,
   input wire logic             init_busy
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0]       left_reg;
   logic [LINES-1:0] mask_reg;
   logic             odd_wr;
   logic             odd_rd;
   assign odd_wr = io_wr && io_addr == pic_init_pkg::ODD_PORT_ADDR;
   assign odd_rd = io_rd && io_addr == pic_init_pkg::ODD_PORT_ADDR;
   // ==================================================================
   // Shadow of the words still awaited and of the mask.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         left_reg <= 2'h0;
         mask_reg <= '0;
      end else if (io_wr && io_addr == pic_init_pkg::EVEN_PORT_ADDR && io_wdata[4]) begin
         left_reg <= 2'h3;
         mask_reg <= '0;
      end else if (odd_wr && left_reg != 2'h0) begin
         left_reg <= left_reg - 2'h1;
      end else if (odd_wr) begin
         mask_reg <= io_wdata[LINES-1:0];
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   // An odd write taken as an init word while n words, this one included, are still awaited.
   sequence word_s(int n);
      odd_wr && left_reg == n;
   endsequence
   busy_track_a: assert property (init_busy == (left_reg != 2'h0))
      else $error("init busy level differs from words awaited");
   vector_base_a: assert property (word_s(3) |=> vector_base == $past(io_wdata[7:3]))
      else $error("vector base not taken from word two");
   cascade_en_a: assert property (word_s(2) |=> cascade_en == $past(io_wdata[2]))
      else $error("cascade enable not taken from word three");
   nest_mode_a: assert property (word_s(1) |=> special_nested == $past(io_wdata[4]))
      else $error("nesting mode not taken from word four");
   eoi_mode_a: assert property (word_s(1) |=> auto_eoi == $past(io_wdata[1]))
      else $error("end of interrupt mode not taken from word four");
   cpu_mode_a: assert property (word_s(1) |=> x86_mode == $past(io_wdata[0]))
      else $error("processor mode not taken from word four");
   mask_read_a: assert property (odd_rd |=> io_rdata_valid && io_rdata == $past(mask_reg))
      else $error("odd port read does not return the mask");
   req_latch_a: assert property (|irq_req |=> (irq_pending & $past(irq_req)) == $past(irq_req))
      else $error("request not latched");
   mask_gate_a: assert property (irq_presented == (irq_pending & ~$past(mask_reg)))
      else $error("presented requests differ from unmasked pending");
endmodule : init_port_checker
bind pic_init_and_mask_port init_port_checker #(.LINES(LINES)) checker_inst (
   .clock(clock), .reset_n(reset_n), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
   .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid),
   .irq_req(irq_req), .irq_pending(irq_pending), .irq_presented(irq_presented),
   .vector_base(vector_base), .cascade_en(cascade_en), .special_nested(special_nested),
   .auto_eoi(auto_eoi), .x86_mode(x86_mode), .init_busy(init_busy));
`default_nettype wire

/* File: dv/io_host_model.sv */
// Host processor model driving the I/O port bus at falling edges.
// Assumes registered read data one cycle after the read strobe.
`default_nettype none
module io_host_model (
   input  wire logic        clock,
   output logic      [15:0] io_addr,
   output logic             io_wr,
   output logic             io_rd,
   output logic      [7:0]  io_wdata,
   input  wire logic [7:0]  io_rdata,
   input  wire logic        io_rdata_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      io_addr  = 16'h0000;
      io_wr    = 1'h0;
      io_rd    = 1'h0;
      io_wdata = 8'h00;
   end
   // One write strobe; data is inverted afterwards so stale data never looks valid.
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge clock);
      io_addr  <= a;
      io_wdata <= d;
      io_wr    <= 1'h1;
      @(negedge clock);
      io_wr    <= 1'h0;
      io_wdata <= ~d;
   endtask : wr
   // One read strobe; the answer is taken in the following cycle.
   task automatic rd(input logic [15:0] a, output logic [8:0] vd);
      @(negedge clock);
      io_addr <= a;
      io_rd   <= 1'h1;
      @(negedge clock);
      io_rd <= 1'h0;
      vd = {io_rdata_valid, io_rdata};
   endtask : rd
   // Full init sequence with every reserved field written as zero.
   task automatic init_seq(input logic [4:0] vec, input logic casc, input logic [2:0] mode);
      wr(pic_init_pkg::EVEN_PORT_ADDR, 8'h11);
      wr(pic_init_pkg::ODD_PORT_ADDR, {vec, 3'h0});
      wr(pic_init_pkg::ODD_PORT_ADDR, {5'h00, casc, 2'h0});
      wr(pic_init_pkg::ODD_PORT_ADDR, {3'h0, mode[2], 2'h0, mode[1:0]});
   endtask : init_seq
endmodule : io_host_model
`default_nettype wire

/* File: dv/pic_init_and_mask_port_bench.sv */
// Self-checking bench for the odd-port programming logic.
// Assumes the host model and the bound checker are compiled alongside.
`default_nettype none
module pic_init_and_mask_port_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock = 1'h0;
   logic        reset_n = 1'h0;
   logic [15:0] io_addr;
   logic        io_wr, io_rd, io_rdata_valid, cascade_en, special_nested;
   logic        auto_eoi, x86_mode, init_busy, init_word_error;
   logic [7:0]  io_wdata, io_rdata, irq_pending, irq_presented;
   logic [7:0]  irq_req = 8'h00;
   logic [7:0]  irq_ack = 8'h00;
   logic [4:0]  vector_base;
   logic [8:0]  vd;
   int          n_checks, miscompares;
   pic_init_and_mask_port dut (.clock(clock), .reset_n(reset_n), .io_addr(io_addr),
      .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
      .io_rdata_valid(io_rdata_valid), .irq_req(irq_req), .irq_ack(irq_ack),
      .irq_pending(irq_pending), .irq_presented(irq_presented), .vector_base(vector_base),
      .cascade_en(cascade_en), .special_nested(special_nested), .auto_eoi(auto_eoi),
      .x86_mode(x86_mode), .init_busy(init_busy), .init_word_error(init_word_error));
   io_host_model host (.clock(clock), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
      .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid));
   always #20 clock = ~clock;
   // ==================================================================
   // Comparison, status word and closing.
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   function automatic logic [15:0] cfg();
      return {5'h00, init_busy, init_word_error, x86_mode, auto_eoi, special_nested,
              cascade_en, vector_base};
   endfunction : cfg
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_of_test
   // Two init sequences with opposite settings of every field.
   task automatic test_init();
      for (int i = 0; i < 2; i++) begin
         host.init_seq(i ? 5'h1E : 5'h01, !i, {i[0], !i[0], !i[0]});
         check(cfg(), {7'h00, !i[0], !i[0], i[0], !i[0], i ? 5'h1E : 5'h01});
      end
      $display("test_init done");
   endtask : test_init
   // Mask write, stray accesses, then requests on all lines and their clearing.
   task automatic test_mask();
      host.wr(pic_init_pkg::ODD_PORT_ADDR, 8'hA5);
      host.wr(16'h0022, 8'h00);
      host.wr(pic_init_pkg::EVEN_PORT_ADDR, 8'h01);
      host.rd(16'h0022, vd);
      check(16'(vd), 16'h0000);
      host.rd(pic_init_pkg::ODD_PORT_ADDR, vd);
      check(16'(vd), 16'h01A5);
      @(negedge clock);
      irq_req <= 8'hFF;
      @(negedge clock);
      irq_req <= 8'h00;
      check({irq_pending, irq_presented}, 16'hFF5A);
      irq_ack <= 8'hFF;
      @(negedge clock);
      irq_ack <= 8'h00;
      check({irq_pending, irq_presented}, 16'h0000);
      $display("test_mask done");
   endtask : test_mask
   // Init restarted after one word, then a word with a reserved bit set.
   task automatic test_restart();
      host.wr(pic_init_pkg::EVEN_PORT_ADDR, 8'h11);
      host.rd(pic_init_pkg::ODD_PORT_ADDR, vd);
      check({7'h00, vd}, 16'h0100);
      check(16'(init_busy), 16'h0001);
      host.wr(pic_init_pkg::ODD_PORT_ADDR, 8'h50);
      host.wr(pic_init_pkg::EVEN_PORT_ADDR, 8'h11);
      host.wr(pic_init_pkg::ODD_PORT_ADDR, 8'h41);
      host.wr(pic_init_pkg::ODD_PORT_ADDR, 8'h00);
      host.wr(pic_init_pkg::ODD_PORT_ADDR, 8'h00);
      check(cfg(), 16'h0208);
      $display("test_restart done");
   endtask : test_restart
   // Main sequence: reset for two cycles, then each test in turn.
   initial begin
      repeat (2) @(posedge clock);
      @(negedge clock);
      reset_n = 1'h1;
      check(cfg(), 16'h0000);
      test_init();
      test_mask();
      test_restart();
      end_of_test();
   end
   // Watchdog well beyond the few dozen cycles the tests need.
   initial begin
      #160000;
      miscompares++;
      end_of_test();
   end
endmodule : pic_init_and_mask_port_bench
`default_nettype wire
